/* core/ssr_pkg.sv */
package ssr_pkg;
  localparam logic [3:0] SSR_ADDR_Y_PWM    = 4'h9;
  localparam logic [3:0] SSR_ADDR_X_FAULT  = 4'hA;
  localparam logic [3:0] SSR_ADDR_Y_FAULT  = 4'hB;
  localparam logic [3:0] SSR_ADDR_CTRL     = 4'h1;
  localparam int         SSR_PAR_BIT       = 7;
  localparam int         SSR_OPEN_BIT      = 6;
  localparam int         SSR_SIGN_BIT      = 5;
  localparam int         SSR_DUTY_MSB      = 4;
  localparam int         SSR_CTRL_DIR_BIT  = 0;
  localparam int         SSR_CTRL_RUN_BIT  = 1;
  localparam int         SSR_CTRL_STEP_BIT = 2;
  localparam logic [1:0] SSR_RESERVED_VAL  = 2'h0;
  localparam logic [7:0] SSR_CTRL_RST      = 8'h00;
  localparam logic [4:0] SSR_DUTY_FULL     = 5'h1F;
  localparam int         SSR_FRAME_BITS    = 16;
  localparam int         SSR_FRAME_CNT_W   = 5;

  typedef enum logic [2:0] {
    SSR_IDLE  = 3'b001,
    SSR_SHIFT = 3'b010,
    SSR_DONE  = 3'b100
  } ssr_state_t;

  // even parity over the seven data bits so the whole byte has even weight
  function automatic logic [7:0] ssr_with_parity(input logic [6:0] data);
    ssr_with_parity = {^data, data};
  endfunction
endpackage

/* core/ssr_sync.sv */
`timescale 1ns/10ps
module ssr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // system clock
  input  wire logic         reset_n, // sync reset, active low
  input  wire logic [W-1:0] async_i, // asynchronous inputs
  output logic      [W-1:0] sync_o   // synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssr_sync_st_t;
  ssr_sync_st_t st_q;
  ssr_sync_st_t st_d;

  always_comb begin
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule

/* core/ssr_status_bank.sv */
`timescale 1ns/10ps
module ssr_status_bank
  import ssr_pkg::*;
(
  input  wire logic       clk,                // system clock, 100 MHz
  input  wire logic       reset_n,            // sync reset, active low
  input  wire logic       spi_cs_n,           // spi chip select pin, active low
  input  wire logic       spi_sclk,           // spi clock pin
  input  wire logic       spi_mosi,           // spi data in pin
  output logic            spi_miso,           // spi data out, registered
  input  wire logic       y_drive_polarity,   // live regulator sign
  input  wire logic [4:0] y_duty_code,        // live regulator duty
  input  wire logic       x_open_evt,         // x open winding detect pulse
  input  wire logic [3:0] x_short_evt,        // x shorts: pgnd, ngnd, psup, nsup
  input  wire logic       y_open_evt,         // y open winding detect pulse
  input  wire logic [3:0] y_short_evt,        // y shorts: pgnd, ngnd, psup, nsup
  output logic            step_pulse,         // one micro-step request
  output logic            step_dir,           // direction from spi
  output logic            run_hold_select,    // run/hold from spi
  output logic            over_current_flag,  // any short latched
  output logic            open_coil_flag,     // any open latched
  output logic            fault_output_oe     // open-drain fault pin pull-low enable
);
  // frame: bit15 write flag, bits 11:8 address, bits 7:0 data
  typedef struct packed {
    ssr_state_t                 state;
    logic [2:0]                 sclk_hist;
    logic [SSR_FRAME_CNT_W-1:0] cnt;
    logic [15:0]                rx;
    logic [7:0]                 tx;
    logic                       miso;
    logic                       x_open;
    logic [3:0]                 x_short;
    logic                       y_open;
    logic [3:0]                 y_short;
    logic [7:0]                 ctrl;
    logic                       step;
  } ssr_st_t;
  ssr_st_t st_q;
  ssr_st_t st_d;

  logic [2:0] pins_s;
  logic       cs_n_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       sclk_rise;
  logic       sclk_fall;
  logic [3:0] addr_w;
  logic [7:0] read_word;
  logic       clr_x;
  logic       clr_y;
  logic       frame_ok;
  logic       wr_ctrl;
  logic       byte_done;
  logic [3:0] addr_now;

  ssr_sync #(.W(3)) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .async_i ({~spi_cs_n, spi_sclk, spi_mosi}),
    .sync_o  (pins_s)
  );

  // select is carried inverted so the cleared flops read as deselected;
  // otherwise a phantom frame would open in the first cycles after reset
  assign cs_n_s = ~pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // edge detect only on synchronised copies
  assign sclk_rise = sclk_s & ~st_q.sclk_hist[0];
  assign sclk_fall = ~sclk_s & st_q.sclk_hist[0];

  // address is known once eight bits are in (write flag, three spare bits, address)
  assign addr_w = st_q.rx[3:0];

  // the read byte is chosen on the rise that brings in the eighth bit
  assign byte_done = (st_q.state == SSR_SHIFT) && !cs_n_s && sclk_rise && (st_q.cnt == 5'h07);
  assign addr_now  = {st_q.rx[2:0], mosi_s};

  // a frame commits only when exactly sixteen bits came before deselect;
  // a cut frame leaves control and flags alone so a glitch cannot clear a fault unseen
  assign frame_ok = (st_q.state == SSR_DONE) && (st_q.cnt == 5'(SSR_FRAME_BITS));
  assign wr_ctrl  = frame_ok && st_q.rx[15] && (st_q.rx[11:8] == SSR_ADDR_CTRL);

  // both fault registers share one layout: open, two reserved zeros, four shorts
  function automatic logic [7:0] fault_byte(input logic coil_open, input logic [3:0] shorts);
    fault_byte = ssr_with_parity({coil_open, SSR_RESERVED_VAL, shorts});
  endfunction

  // reading builds the word from live state; sign and duty never latched
  function automatic logic [7:0] read_mux(input logic [3:0] a, input ssr_st_t s,
                                          input logic pol, input logic [4:0] duty);
    case (a)
      SSR_ADDR_Y_PWM:   read_mux = ssr_with_parity({1'b0, pol, duty});
      SSR_ADDR_X_FAULT: read_mux = fault_byte(s.x_open, s.x_short);
      SSR_ADDR_Y_FAULT: read_mux = fault_byte(s.y_open, s.y_short);
      SSR_ADDR_CTRL:    read_mux = s.ctrl;
      default:          read_mux = 8'h00;
    endcase
  endfunction

  assign read_word = read_mux(addr_w, st_q, y_drive_polarity, y_duty_code);

  always_comb begin
    st_d = st_q;
    st_d.sclk_hist = {st_q.sclk_hist[1:0], sclk_s};
    // step is a one-cycle strobe that falls back by itself
    st_d.step = 1'b0;
    clr_x = 1'b0;
    clr_y = 1'b0;
    case (st_q.state)
      SSR_IDLE: begin
        st_d.cnt = '0;
        st_d.miso = 1'b0;
        if (!cs_n_s) begin
          st_d.state = SSR_SHIFT;
        end
      end
      SSR_SHIFT: begin
        if (cs_n_s) begin
          st_d.state = SSR_DONE;
        end else begin
          if (sclk_rise) begin
            st_d.rx = {st_q.rx[14:0], mosi_s};
            st_d.cnt = st_q.cnt + 5'h01;
            // after 8 bits, latch read data for the second byte
            if (st_q.cnt == 5'h07) begin
              st_d.tx = read_mux({st_q.rx[2:0], mosi_s}, st_q, y_drive_polarity, y_duty_code);
            end
          end
          if (sclk_fall && st_q.cnt >= 5'h08) begin
            st_d.miso = st_q.tx[7];
            st_d.tx = {st_q.tx[6:0], 1'b0};
          end
        end
      end
      SSR_DONE: begin
        st_d.state = SSR_IDLE;
        // only a complete frame commits; a read of a fault register clears that register's flags
        if (st_q.cnt == 5'(SSR_FRAME_BITS)) begin
          if (st_q.rx[15]) begin
            if (st_q.rx[11:8] == SSR_ADDR_CTRL) begin
              st_d.ctrl = st_q.rx[7:0];
              st_d.step = st_q.rx[SSR_CTRL_STEP_BIT];
              st_d.ctrl[SSR_CTRL_STEP_BIT] = 1'b0;
            end
          end else begin
            clr_x = (st_q.rx[11:8] == SSR_ADDR_X_FAULT);
            clr_y = (st_q.rx[11:8] == SSR_ADDR_Y_FAULT);
          end
        end
      end
      default: begin
        st_d.state = SSR_IDLE;
      end
    endcase
    // set wins over the clear-on-read
    st_d.x_open  = (st_q.x_open & ~clr_x) | x_open_evt;
    st_d.x_short = (st_q.x_short & {4{~clr_x}}) | x_short_evt;
    st_d.y_open  = (st_q.y_open & ~clr_y) | y_open_evt;
    st_d.y_short = (st_q.y_short & {4{~clr_y}}) | y_short_evt;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '{state: SSR_IDLE, ctrl: SSR_CTRL_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // summaries are plain ors of the latched bits, so they drop with the clear
  assign spi_miso          = st_q.miso;
  assign step_pulse        = st_q.step;
  assign step_dir          = st_q.ctrl[SSR_CTRL_DIR_BIT];
  assign run_hold_select   = st_q.ctrl[SSR_CTRL_RUN_BIT];
  assign over_current_flag = |{st_q.x_short, st_q.y_short};
  assign open_coil_flag    = st_q.x_open | st_q.y_open;
  assign fault_output_oe   = over_current_flag | open_coil_flag;

  a_x_open_sets: assert property (@(posedge clk) disable iff (!reset_n)
    x_open_evt |=> st_q.x_open) else $error("x open not latched");
  a_y_open_sets: assert property (@(posedge clk) disable iff (!reset_n)
    y_open_evt |=> st_q.y_open) else $error("y open not latched");
  a_x_short_sets: assert property (@(posedge clk) disable iff (!reset_n)
    |x_short_evt |=> over_current_flag) else $error("x short lost");
  a_y_short_map: assert property (@(posedge clk) disable iff (!reset_n)
    y_short_evt[3] |=> st_q.y_short[3]) else $error("y short bit 3 lost");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
    addr_w == SSR_ADDR_X_FAULT |-> read_word[5:4] == 2'h0) else $error("reserved bits set");
  a_parity_even: assert property (@(posedge clk) disable iff (!reset_n)
    addr_w == SSR_ADDR_Y_FAULT |-> ^read_word == 1'b0) else $error("parity odd");
  a_y_live_read: assert property (@(posedge clk) disable iff (!reset_n)
    addr_w == SSR_ADDR_Y_PWM |-> read_word[5:0] == {y_drive_polarity, y_duty_code})
    else $error("y pwm not live");
  a_open_summary: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.x_open || st_q.y_open) |-> open_coil_flag) else $error("open summary wrong");
  a_short_summary: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.y_short[0]) |-> over_current_flag) else $error("short summary wrong");
  a_clear_on_read: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_x && !x_open_evt) |=> !st_q.x_open) else $error("x open not cleared");
  a_step_once: assert property (@(posedge clk) disable iff (!reset_n)
    step_pulse |=> !step_pulse) else $error("step longer than one cycle");
  a_dir_write: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == SSR_DONE && st_q.cnt == 5'h10 && st_q.rx[15] && st_q.rx[11:8] == SSR_ADDR_CTRL)
    |=> step_dir == $past(st_q.rx[0])) else $error("direction not written");

  // every short bit lands in its own place
  a_x_short_pg: assert property (@(posedge clk) disable iff (!reset_n)
    x_short_evt[3] |=> st_q.x_short[3]) else $error("x short bit 3 lost");
  a_x_short_ng: assert property (@(posedge clk) disable iff (!reset_n)
    x_short_evt[2] |=> st_q.x_short[2]) else $error("x short bit 2 lost");
  a_x_short_ps: assert property (@(posedge clk) disable iff (!reset_n)
    x_short_evt[1] |=> st_q.x_short[1]) else $error("x short bit 1 lost");
  a_x_short_ns: assert property (@(posedge clk) disable iff (!reset_n)
    x_short_evt[0] |=> st_q.x_short[0]) else $error("x short bit 0 lost");
  a_y_short_ng: assert property (@(posedge clk) disable iff (!reset_n)
    y_short_evt[2] |=> st_q.y_short[2]) else $error("y short bit 2 lost");
  a_y_short_ps: assert property (@(posedge clk) disable iff (!reset_n)
    y_short_evt[1] |=> st_q.y_short[1]) else $error("y short bit 1 lost");
  a_y_short_ns: assert property (@(posedge clk) disable iff (!reset_n)
    y_short_evt[0] |=> st_q.y_short[0]) else $error("y short bit 0 lost");

  // clear-on-read takes every latched bit, unless a new event lands with it
  a_x_clear_short: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_x && x_short_evt == 4'h0) |=> st_q.x_short == 4'h0) else $error("x shorts not cleared");
  a_y_clear_open: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_y && !y_open_evt) |=> !st_q.y_open) else $error("y open not cleared");
  a_y_clear_short: assert property (@(posedge clk) disable iff (!reset_n)
    (clr_y && y_short_evt == 4'h0) |=> st_q.y_short == 4'h0) else $error("y shorts not cleared");
  a_write_no_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (frame_ok && st_q.rx[15]) |-> (!clr_x && !clr_y)) else $error("write cleared flags");
  a_cut_no_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == SSR_DONE && !frame_ok) |-> (!clr_x && !clr_y)) else $error("cut frame cleared flags");

  // read byte latched at the eighth bit
  a_x_tx_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && addr_now == SSR_ADDR_X_FAULT) |=> st_q.tx[5:4] == 2'h0) else $error("x reserved bits set");
  a_y_tx_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && addr_now == SSR_ADDR_Y_FAULT) |=> st_q.tx[5:4] == 2'h0) else $error("y reserved bits set");
  a_y_pwm_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && addr_now == SSR_ADDR_Y_PWM)
    |=> st_q.tx == ssr_with_parity({1'b0, $past(y_drive_polarity), $past(y_duty_code)})) else $error("y pwm byte wrong");
  a_tx_parity: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && addr_now != SSR_ADDR_CTRL) |=> ^st_q.tx == 1'b0) else $error("read byte parity odd");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && addr_now != SSR_ADDR_Y_PWM && addr_now != SSR_ADDR_X_FAULT && addr_now != SSR_ADDR_Y_FAULT
     && addr_now != SSR_ADDR_CTRL) |=> st_q.tx == 8'h00) else $error("unmapped read not zero");

  // control writes and the refusal of cut frames
  a_run_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl |=> run_hold_select == $past(st_q.rx[SSR_CTRL_RUN_BIT])) else $error("run/hold not written");
  a_step_write: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_ctrl && st_q.rx[SSR_CTRL_STEP_BIT]) |=> step_pulse) else $error("step not issued");
  a_step_selfclear: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.ctrl[SSR_CTRL_STEP_BIT] == 1'b0) else $error("step bit held");
  a_cut_frame: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == SSR_DONE && !frame_ok) |=> (!step_pulse && $stable(st_q.ctrl))) else $error("cut frame committed");

  // frame sequencing; miso rests low between frames
  a_shift_exit: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == SSR_SHIFT && cs_n_s) |=> st_q.state == SSR_DONE) else $error("frame end missed");
  a_done_idle: assert property (@(posedge clk) disable iff (!reset_n)
    st_q.state == SSR_DONE |=> st_q.state == SSR_IDLE) else $error("done not left");
  a_miso_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (st_q.state == SSR_IDLE && $past(st_q.state) == SSR_IDLE) |-> !spi_miso) else $error("miso not low at rest");

  // summaries follow any latched bit at once
  a_x_short_summary: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.x_short[3]) |-> over_current_flag) else $error("x short summary wrong");
  a_x_open_summary: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.x_open) |-> open_coil_flag) else $error("x open summary wrong");
  a_y_open_summary: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(st_q.y_open) |-> (open_coil_flag && fault_output_oe)) else $error("y open summary wrong");
  a_fault_pin_any: assert property (@(posedge clk) disable iff (!reset_n)
    (over_current_flag || open_coil_flag) |-> fault_output_oe) else $error("fault pin not driven");

  // main scenarios
  c_cut_frame: cover property (@(posedge clk) disable iff (!reset_n) st_q.state == SSR_DONE && !frame_ok);
  c_step: cover property (@(posedge clk) disable iff (!reset_n) step_pulse);
  c_clear_x: cover property (@(posedge clk) disable iff (!reset_n) clr_x && st_q.x_open);
  c_set_clear: cover property (@(posedge clk) disable iff (!reset_n) clr_y && y_open_evt);
  c_full_duty: cover property (@(posedge clk) disable iff (!reset_n) y_duty_code == SSR_DUTY_FULL);
endmodule

/* bench/ssr_spi_host.sv */
`timescale 1ns/10ps
// behavioural spi master; sclk idles low and stands still outside frames
module ssr_spi_host #(
  parameter int HALF = 6
) (
  input  wire logic clk,  // system clock
  output logic      cs_n, // chip select, active low
  output logic      sclk, // spi clock
  output logic      mosi, // data to device
  input  wire logic miso  // data from device
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // n below 16 makes a broken frame; half periods stay above the 4-cycle minimum
  task automatic xfer(input logic [15:0] frame, input int n, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = frame[15-i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      if (i >= 8) rx = {rx[6:0], miso};
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    // released data line shows the inverse, not a held last bit
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* bench/stepper_status_readout_tb.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module stepper_status_readout_tb;
  import ssr_pkg::*;
  logic       clk, reset_n, cs_n, sclk, mosi, miso, pol, x_open, y_open;
  logic [4:0] duty;
  logic [3:0] xs, ys;
  logic       step, dir, run, ocf, ocl, foe;
  logic [7:0] rd;
  int         n_mismatch, check_count, step_cnt, step_base;

  ssr_status_bank dut (.clk(clk), .reset_n(reset_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .spi_miso(miso), .y_drive_polarity(pol), .y_duty_code(duty), .x_open_evt(x_open), .x_short_evt(xs),
    .y_open_evt(y_open), .y_short_evt(ys), .step_pulse(step), .step_dir(dir), .run_hold_select(run),
    .over_current_flag(ocf), .open_coil_flag(ocl), .fault_output_oe(foe));
  ssr_spi_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

  function automatic logic [7:0] par8(input logic [6:0] d);
    return {^d, d};
  endfunction

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one fault burst on one coil, then a broken frame, a polling read and a second read
  task automatic fault(input bit is_y, input logic op, input logic [3:0] sh);
    logic [7:0] v;
    logic [3:0] a;
    a = is_y ? SSR_ADDR_Y_FAULT : SSR_ADDR_X_FAULT;
    @(negedge clk);
    if (is_y) begin
      y_open = op;
      ys = sh;
    end else begin
      x_open = op;
      xs = sh;
    end
    @(negedge clk);
    {x_open, y_open, xs, ys} = '0;
    repeat (3) @(negedge clk);
    `CHK("over_current", |sh, ocf)
    `CHK("open_coil", op, ocl)
    `CHK("fault_oe", op | (|sh), foe)
    host.xfer({4'h0, a, 8'h00}, 12, v);
    host.xfer({1'b0, 3'($urandom), a, 8'h00}, 16, v);
    `CHK("fault_reg", par8({op, 2'b00, sh}), v)
    host.xfer({4'h0, a, 8'h00}, 16, v);
    `CHK("fault_clear", 8'h00, v)
    `CHK("summary_clear", 2'b00, {ocf, ocl})
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole sequence needs well under 15000 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  always @(posedge clk) if (step === 1'b1) step_cnt++;

  initial begin
    {reset_n, pol, duty, x_open, xs, y_open, ys} = '0;
    n_mismatch = 0;
    check_count = 0;
    void'($urandom(90));
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("reset_outs", 5'h00, {ocf, ocl, foe, dir, run})
    for (int i = 0; i < 10; i++) begin
      pol = (i == 0) ? 1'b1 : 1'($urandom);
      duty = (i == 0) ? SSR_DUTY_FULL : (i == 1) ? 5'h00 : 5'($urandom);
      host.xfer({1'b0, 3'($urandom), SSR_ADDR_Y_PWM, 8'h00}, 16, rd);
      `CHK("y_pwm", par8({1'b0, pol, duty}), rd)
    end
    for (int i = 0; i < 8; i++) begin
      fault(i[0], (i < 2) ? 1'b1 : 1'($urandom), (i < 2) ? 4'hF : 4'($urandom));
    end
    step_base = step_cnt;
    host.xfer({4'h8, SSR_ADDR_CTRL, 8'h07}, 16, rd);
    `CHK("steps", step_base + 1, step_cnt)
    `CHK("dir_run", 2'b11, {dir, run})
    host.xfer({4'h8, SSR_ADDR_CTRL, 8'h00}, 16, rd);
    `CHK("steps_held", step_base + 1, step_cnt)
    `CHK("dir_run_off", 2'b00, {dir, run})
    host.xfer({4'h0, 4'h3, 8'h00}, 16, rd);
    `CHK("unmapped", 8'h00, rd)
    stop_test();
  end
endmodule
